// ---- status_readback_pkg.sv ----
// Shared constants for the display status readback block
package status_readback_pkg;

  // ------------------------------------------------------------
  // Command codes taken while data/command select is low
  // ------------------------------------------------------------
  localparam logic [7:0] CMD_READ_STATUS = 8'h09;
  localparam logic [7:0] CMD_READ_POWER = 8'h0a;

  // ------------------------------------------------------------
  // Reset values and read framing
  // ------------------------------------------------------------
  localparam logic [31:0] DISPLAY_STATUS_RESET = 32'h00610000;
  localparam logic [7:0] POWER_MODE_RESET = 8'h08;
  localparam logic [7:0] DUMMY_BYTE = 8'h00;
  localparam logic [7:0] IDLE_READ_BYTE = 8'h00;
  localparam logic [2:0] STATUS_DATA_BYTES = 3'h4;
  localparam logic [2:0] POWER_DATA_BYTES = 3'h1;

  // ------------------------------------------------------------
  // Memory access control bit positions
  // ------------------------------------------------------------
  localparam int MAC_ROW_ORDER = 7;
  localparam int MAC_COLUMN_ORDER = 6;
  localparam int MAC_ROW_COLUMN_SWAP = 5;
  localparam int MAC_REFRESH_DIRECTION = 4;
  localparam int MAC_COLOUR_ORDER = 3;

  // ------------------------------------------------------------
  // Display status word bit positions
  // ------------------------------------------------------------
  localparam int DSW_BOOSTER_OK = 31;
  localparam int DSW_ROW_ORDER = 30;
  localparam int DSW_COLUMN_ORDER = 29;
  localparam int DSW_ROW_COLUMN_SWAP = 28;
  localparam int DSW_REFRESH_DIRECTION = 27;
  localparam int DSW_COLOUR_ORDER = 26;
  localparam int DSW_PIXEL_FORMAT_LSB = 20;
  localparam int DSW_IDLE = 19;
  localparam int DSW_PARTIAL = 18;
  localparam int DSW_AWAKE = 17;
  localparam int DSW_NORMAL = 16;
  localparam int DSW_INVERSION = 13;
  localparam int DSW_DISPLAY_ON = 10;
  localparam int DSW_TEAR_ENABLE = 9;
  localparam int DSW_TEAR_MODE = 5;

  // ------------------------------------------------------------
  // Power mode byte bit positions
  // ------------------------------------------------------------
  localparam int PMB_BOOSTER_OK = 7;
  localparam int PMB_IDLE = 6;
  localparam int PMB_PARTIAL = 5;
  localparam int PMB_AWAKE_FLAG_PM = 4;
  localparam int PMB_NORMAL = 3;
  localparam int PMB_DISPLAY_ON = 2;

  // ------------------------------------------------------------
  // Pin synchroniser layout and idle levels
  // ------------------------------------------------------------
  localparam int PIN_WIDTH = 11;
  localparam int PIN_DATA_LSB = 0;
  localparam int PIN_READ_STROBE = 8;
  localparam int PIN_WRITE_STROBE = 9;
  localparam int PIN_DATA_COMMAND = 10;
  localparam logic [10:0] PIN_IDLE = 11'h700;

  // Readback sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_DUMMY,
    ST_DATA
  } read_state_t;

endpackage

// ---- status_if.sv ----
// Interface carrying the assembled status word and power byte
`timescale 1ns/100ps
interface status_if;
  logic [31:0] status_word; // Display status word, registered
  logic [7:0] power_mode; // Power mode byte, registered

  modport producer (output status_word, output power_mode);
  modport consumer (input status_word, input power_mode);
endinterface

// ---- pin_sync.sv ----
// Three-stage pin synchroniser that accepts a level once two stages agree
`timescale 1ns/100ps
module pin_sync
  import status_readback_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [PIN_WIDTH-1:0] pin_in,
  output logic [PIN_WIDTH-1:0] pin_out
);

  // ------------------------------------------------------------
  // Per-bit stages
  // ------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < PIN_WIDTH; gi++) begin : g_bit
      logic s1_ff; // Metastability catcher, read only by s2
      logic s2_ff;
      logic s3_ff;
      logic out_ff;
      logic nxt_out;

      // Accept a new level only once the last two stages agree
      always_comb begin
        nxt_out = out_ff;
        if (s2_ff == s3_ff) begin
          nxt_out = s3_ff;
        end
      end

      // Stages reset to the idle level of their pin
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          s1_ff <= PIN_IDLE[gi];
          s2_ff <= PIN_IDLE[gi];
          s3_ff <= PIN_IDLE[gi];
          out_ff <= PIN_IDLE[gi];
        end else begin
          s1_ff <= pin_in[gi];
          s2_ff <= s1_ff;
          s3_ff <= s2_ff;
          out_ff <= nxt_out;
        end
      end

      assign pin_out[gi] = out_ff;
    end
  endgenerate

endmodule // pin_sync

// ---- status_assembler.sv ----
// Builds the display status word and power mode byte from live mode flags
`timescale 1ns/100ps
module status_assembler
  import status_readback_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] memory_access_control,
  input wire logic [2:0] pixel_format_field,
  input wire logic idle_active_flag,
  input wire logic partial_active_flag,
  input wire logic awake_flag,
  input wire logic normal_display_flag,
  input wire logic inversion_active_flag,
  input wire logic display_on_flag,
  input wire logic tear_output_enable_flag,
  input wire logic tear_output_mode_flag,
  input wire logic booster_ok_flag,
  status_if.producer stat
);

  logic [31:0] word_ff; // Registered status word
  logic [7:0] power_ff; // Registered power byte
  logic [31:0] nxt_word;
  logic [7:0] nxt_power;

  // ------------------------------------------------------------
  // Field placement; unlisted bits stay zero
  // ------------------------------------------------------------
  always_comb begin
    nxt_word = 32'h00000000;
    nxt_word[DSW_BOOSTER_OK] = booster_ok_flag;
    nxt_word[DSW_ROW_ORDER] = memory_access_control[MAC_ROW_ORDER]; // [RQ1]
    nxt_word[DSW_COLUMN_ORDER] = memory_access_control[MAC_COLUMN_ORDER]; // [RQ2]
    nxt_word[DSW_ROW_COLUMN_SWAP] = memory_access_control[MAC_ROW_COLUMN_SWAP]; // [RQ3]
    nxt_word[DSW_REFRESH_DIRECTION] = memory_access_control[MAC_REFRESH_DIRECTION]; // [RQ4]
    nxt_word[DSW_COLOUR_ORDER] = memory_access_control[MAC_COLOUR_ORDER]; // [RQ5]
    nxt_word[DSW_PIXEL_FORMAT_LSB +: 3] = pixel_format_field; // [RQ6]
    nxt_word[DSW_IDLE] = idle_active_flag; // [RQ7]
    nxt_word[DSW_PARTIAL] = partial_active_flag; // [RQ7]
    nxt_word[DSW_AWAKE] = awake_flag; // [RQ7]
    nxt_word[DSW_NORMAL] = normal_display_flag; // [RQ7]
    nxt_word[DSW_INVERSION] = inversion_active_flag; // [RQ8]
    nxt_word[DSW_DISPLAY_ON] = display_on_flag; // [RQ8]
    nxt_word[DSW_TEAR_ENABLE] = tear_output_enable_flag; // [RQ8]
    nxt_word[DSW_TEAR_MODE] = tear_output_mode_flag; // [RQ9]
    nxt_power = 8'h00; // Low two bits read zero [RQ10]
    nxt_power[PMB_BOOSTER_OK] = booster_ok_flag; // [RQ10]
    nxt_power[PMB_IDLE] = idle_active_flag; // [RQ10]
    nxt_power[PMB_PARTIAL] = partial_active_flag; // [RQ10]
    nxt_power[PMB_AWAKE_FLAG_PM] = awake_flag; // [RQ10]
    nxt_power[PMB_NORMAL] = normal_display_flag; // [RQ10]
    nxt_power[PMB_DISPLAY_ON] = display_on_flag; // [RQ10]
  end

  // Registered so a read byte never sees a half-updated mode change
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      word_ff <= DISPLAY_STATUS_RESET; // [RQ12]
      power_ff <= POWER_MODE_RESET; // [RQ12]
    end else begin
      word_ff <= nxt_word;
      power_ff <= nxt_power;
    end
  end

  assign stat.status_word = word_ff;
  assign stat.power_mode = power_ff;

endmodule // status_assembler

// ---- status_readback.sv ----
// Top of the status readback command interpreter on the host command bus
//
// What this block does
// [RQ1] Row order bit mirrors access control bit 7
// [RQ2] Column order bit mirrors access control bit 6
// [RQ3] Swap bit mirrors access control bit 5
// [RQ4] Refresh direction mirrors access control bit 4
// [RQ5] Colour order mirrors access control bit 3
// [RQ6] Pixel format field reports 011/101/110 encodings
// [RQ7] Partial, awake, normal, idle flags read active-high
// [RQ8] Inversion, display on, tear enable read active-high
// [RQ9] Tear mode bit: zero vertical, one both
// [RQ10] Power byte: booster, modes, low bits zero
// [RQ11] Command, then dummy read, then data reads
// [RQ12] Reset values 00610000 and 08
// [RQ13] Reads work in every power state
`timescale 1ns/100ps
module status_readback
  import status_readback_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic data_command_select,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  input wire logic [7:0] memory_access_control,
  input wire logic [2:0] pixel_format_field,
  input wire logic idle_active_flag,
  input wire logic partial_active_flag,
  input wire logic awake_flag,
  input wire logic normal_display_flag,
  input wire logic inversion_active_flag,
  input wire logic display_on_flag,
  input wire logic tear_output_enable_flag,
  input wire logic tear_output_mode_flag,
  input wire logic booster_ok_flag
);

  // ------------------------------------------------------------
  // Pin synchronisation
  // ------------------------------------------------------------
  logic [PIN_WIDTH-1:0] pins_raw; // Pins as they arrive
  logic [PIN_WIDTH-1:0] pins_sync; // Pins after agreement filter
  logic dc_s; // Synchronised data/command select
  logic wr_s; // Synchronised write strobe, low active
  logic rd_s; // Synchronised read strobe, low active
  logic [7:0] bus_s; // Synchronised data lines

  assign pins_raw = {data_command_select, write_strobe_n, read_strobe_n, data_in};

  pin_sync u_pin_sync (
    .clk(clk),
    .rst_b(rst_b),
    .pin_in(pins_raw),
    .pin_out(pins_sync)
  );

  // Data travels the same path as the strobes, so they stay aligned
  assign dc_s = pins_sync[PIN_DATA_COMMAND];
  assign wr_s = pins_sync[PIN_WRITE_STROBE];
  assign rd_s = pins_sync[PIN_READ_STROBE];
  assign bus_s = pins_sync[PIN_DATA_LSB +: 8];

  // ------------------------------------------------------------
  // Status assembly
  // ------------------------------------------------------------
  status_if stat ();

  status_assembler u_status_assembler (
    .clk(clk),
    .rst_b(rst_b),
    .memory_access_control(memory_access_control),
    .pixel_format_field(pixel_format_field),
    .idle_active_flag(idle_active_flag),
    .partial_active_flag(partial_active_flag),
    .awake_flag(awake_flag),
    .normal_display_flag(normal_display_flag),
    .inversion_active_flag(inversion_active_flag),
    .display_on_flag(display_on_flag),
    .tear_output_enable_flag(tear_output_enable_flag),
    .tear_output_mode_flag(tear_output_mode_flag),
    .booster_ok_flag(booster_ok_flag),
    .stat(stat)
  );

  // ------------------------------------------------------------
  // Sequencer state
  // ------------------------------------------------------------
  read_state_t state_ff; // Where the read sequence stands
  read_state_t nxt_state;
  logic is_status_ff; // One for the status word, zero for power byte
  logic nxt_is_status;
  logic [2:0] idx_ff; // Data byte number, zero based
  logic [2:0] nxt_idx;
  logic wr_prev_ff; // Last write strobe level, for edges
  logic rd_prev_ff; // Last read strobe level, for edges
  logic [7:0] data_out_ff; // Byte on the data lines
  logic [7:0] nxt_data_out;
  logic data_oe_ff; // High while the lines are driven
  logic nxt_data_oe;
  logic wr_rise; // End of a write strobe
  logic rd_fall; // Start of a read strobe
  logic rd_rise; // End of a read strobe
  logic [7:0] data_byte; // Data byte for the current index
  logic [2:0] last_idx; // Index of the final data byte

  assign wr_rise = wr_s && !wr_prev_ff;
  assign rd_fall = !rd_s && rd_prev_ff;
  assign rd_rise = rd_s && !rd_prev_ff;
  assign last_idx = (is_status_ff ? STATUS_DATA_BYTES : POWER_DATA_BYTES) - 3'h1;

  // Pick the byte, most significant first
  always_comb begin
    data_byte = stat.power_mode;
    if (is_status_ff) begin
      case (idx_ff)
        3'h0: data_byte = stat.status_word[31:24];
        3'h1: data_byte = stat.status_word[23:16];
        3'h2: data_byte = stat.status_word[15:8];
        default: data_byte = stat.status_word[7:0];
      endcase
    end
  end

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  // No power-state check anywhere: readback is always answered [RQ13]
  always_comb begin
    nxt_state = state_ff;
    nxt_is_status = is_status_ff;
    nxt_idx = idx_ff;
    nxt_data_out = data_out_ff;
    nxt_data_oe = data_oe_ff;
    if (wr_rise) begin
      // Any write ends a read in progress; only a command starts one
      nxt_state = ST_IDLE;
      nxt_idx = 3'h0;
      if (!dc_s && (bus_s == CMD_READ_STATUS || bus_s == CMD_READ_POWER)) begin
        nxt_state = ST_DUMMY; // [RQ11]
        nxt_is_status = (bus_s == CMD_READ_STATUS);
      end
    end else if (rd_fall && dc_s) begin
      // Drive the byte for the whole low phase of the read strobe [RQ13]
      nxt_data_oe = 1'b1;
      case (state_ff)
        ST_DUMMY: nxt_data_out = DUMMY_BYTE; // [RQ11]
        ST_DATA: nxt_data_out = data_byte; // [RQ11]
        default: nxt_data_out = IDLE_READ_BYTE;
      endcase
    end else if (rd_rise) begin
      // Release the lines and step on to the next byte
      nxt_data_oe = 1'b0;
      case (state_ff)
        ST_DUMMY: begin
          nxt_state = ST_DATA;
          nxt_idx = 3'h0;
        end
        ST_DATA: begin
          if (idx_ff == last_idx) begin
            nxt_state = ST_IDLE;
          end else begin
            nxt_idx = idx_ff + 3'h1;
          end
        end
        default: nxt_state = ST_IDLE;
      endcase
    end
  end

  // Registers only; all outputs leave straight from here
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= ST_IDLE;
      is_status_ff <= 1'b0;
      idx_ff <= 3'h0;
      wr_prev_ff <= 1'b1;
      rd_prev_ff <= 1'b1;
      data_out_ff <= 8'h00;
      data_oe_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      is_status_ff <= nxt_is_status;
      idx_ff <= nxt_idx;
      wr_prev_ff <= wr_s;
      rd_prev_ff <= rd_s;
      data_out_ff <= nxt_data_out;
      data_oe_ff <= nxt_data_oe;
    end
  end

  assign data_out = data_out_ff;
  assign data_oe = data_oe_ff;

endmodule // status_readback

// ---- status_readback_monitor.sv ----
// Checker for the status readback block, bound to its top ports
`timescale 1ns/100ps
module status_readback_monitor
  import status_readback_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic data_command_select,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  input wire logic [7:0] memory_access_control,
  input wire logic [2:0] pixel_format_field,
  input wire logic idle_active_flag,
  input wire logic partial_active_flag,
  input wire logic awake_flag,
  input wire logic normal_display_flag,
  input wire logic inversion_active_flag,
  input wire logic display_on_flag,
  input wire logic tear_output_enable_flag,
  input wire logic tear_output_mode_flag,
  input wire logic booster_ok_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ----------------------------------------
  // Helper state: last write and read index
  // ----------------------------------------
  logic [7:0] cmd_ff, nxt_cmd; // Last written byte, ff after a data write
  logic [2:0] idx_ff, nxt_idx; // Reads since that write, saturating
  logic [3:0] hi_ff, nxt_hi; // Cycles the read strobe has stayed high
  logic rd_q_ff, wr_q_ff; // Strobe levels one edge back
  logic okidx; // Read index that carries real data
  // Pin-level tracking runs ahead of the design's synchroniser on purpose
  always_comb begin
    nxt_cmd = cmd_ff;
    nxt_idx = idx_ff;
    nxt_hi = read_strobe_n ? hi_ff + {3'h0, hi_ff != 4'hf} : 4'h0;
    if (!wr_q_ff && write_strobe_n) begin
      nxt_cmd = data_command_select ? 8'hff : data_in;
      nxt_idx = 3'h0;
    end else if (rd_q_ff && !read_strobe_n && data_command_select && idx_ff != 3'h7) begin
      nxt_idx = idx_ff + 3'h1;
    end
  end
  assign okidx = idx_ff > 3'h1 && (cmd_ff == 8'h09 ? idx_ff < 3'h6 : cmd_ff == 8'h0a && idx_ff == 3'h2);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      {cmd_ff, idx_ff, hi_ff, rd_q_ff, wr_q_ff} <= {8'h00, 3'h0, 4'h0, 2'h3};
    end else begin
      {cmd_ff, idx_ff, hi_ff, rd_q_ff, wr_q_ff} <= {nxt_cmd, nxt_idx, nxt_hi, read_strobe_n, write_strobe_n};
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  reset_quiet_a: assert property ($rose(rst_b) |-> !data_oe && data_out == 8'h00)
    else $error("output active right after reset");
  oe_rise_a: assert property ($fell(read_strobe_n) && data_command_select |-> ##[4:6] data_oe)
    else $error("read strobe not answered");
  oe_drop_a: assert property ($rose(read_strobe_n) |-> ##[4:6] !data_oe)
    else $error("data lines not released");
  oe_window_a: assert property (data_oe |-> hi_ff <= 4'h5)
    else $error("driving outside a read phase");
  byte_hold_a: assert property (data_oe && $past(data_oe) |-> $stable(data_out))
    else $error("read byte changed mid phase");
  dummy_byte_a: assert property ($rose(data_oe) && idx_ff == 3'h1 |-> data_out == 8'h00)
    else $error("first read not dummy");
  power_byte_a: assert property ($rose(data_oe) && cmd_ff == 8'h0a && idx_ff == 3'h2 |-> data_out ==
    {booster_ok_flag, idle_active_flag, partial_active_flag, awake_flag, normal_display_flag,
     display_on_flag, 2'b00})
    else $error("power byte wrong");
  status_top_a: assert property ($rose(data_oe) && cmd_ff == 8'h09 && idx_ff == 3'h2
    |-> data_out == {booster_ok_flag, memory_access_control[7:3], 2'b00})
    else $error("status byte one wrong");
  status_mode_a: assert property ($rose(data_oe) && cmd_ff == 8'h09 && idx_ff == 3'h3
    |-> data_out == {1'b0, pixel_format_field, idle_active_flag, partial_active_flag, awake_flag,
    normal_display_flag})
    else $error("status byte two wrong");
  status_disp_a: assert property ($rose(data_oe) && cmd_ff == 8'h09 && idx_ff == 3'h4 |-> data_out ==
    {2'b00, inversion_active_flag, 2'b00, display_on_flag, tear_output_enable_flag, 1'b0})
    else $error("status byte three wrong");
  tear_mode_a: assert property ($rose(data_oe) && cmd_ff == 8'h09 && idx_ff == 3'h5 |-> data_out ==
    {2'b00, tear_output_mode_flag, 5'h00})
    else $error("status byte four wrong");
  idle_read_a: assert property ($rose(data_oe) && !okidx |-> data_out == 8'h00)
    else $error("idle read not zero");
endmodule // status_readback_monitor
bind status_readback status_readback_monitor status_readback_monitor_inst (.clk, .rst_b, .data_command_select,
  .write_strobe_n, .read_strobe_n, .data_in, .data_out, .data_oe, .memory_access_control, .pixel_format_field,
  .idle_active_flag, .partial_active_flag, .awake_flag, .normal_display_flag, .inversion_active_flag,
  .display_on_flag, .tear_output_enable_flag, .tear_output_mode_flag, .booster_ok_flag);

// ---- status_host_model.sv ----
// Host controller model driving the command bus pins
`timescale 1ns/100ps
module status_host_model (
  input wire logic clk,
  output logic data_command_select,
  output logic write_strobe_n,
  output logic read_strobe_n,
  output logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic data_oe
);
  logic [7:0] hb_ff; // Last byte the host put out
  logic hoe_ff; // High while the host drives the data lines
  // No pull on the lines: released, they show the inverse of the last byte
  assign data_in = data_oe ? data_out : (hoe_ff ? hb_ff : ~hb_ff);
  initial begin
    {data_command_select, write_strobe_n, read_strobe_n, hoe_ff, hb_ff} = {4'he, 8'h00};
  end
  // Write phase: strobe low six cycles, byte held six past its rising edge
  task automatic send(input logic dc, input logic [7:0] v);
    @(posedge clk);
    {data_command_select, hb_ff, hoe_ff, write_strobe_n} <= {dc, v, 2'b10};
    repeat (6) @(posedge clk);
    write_strobe_n <= 1'b1;
    repeat (6) @(posedge clk);
    {hoe_ff, data_command_select} <= 2'b01;
    repeat (4) @(posedge clk);
  endtask
  // Read phase of eight cycles; a byte the device did not drive reads unknown
  task automatic fetch(output logic [7:0] b);
    @(posedge clk);
    read_strobe_n <= 1'b0;
    repeat (8) @(posedge clk);
    b = data_oe ? data_in : 8'hxx;
    read_strobe_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
endmodule // status_host_model

// ---- tb_status_readback.sv ----
// Self-checking bench for the status readback block
`timescale 1ns/100ps
module tb_status_readback;
  import status_readback_pkg::*;
  logic clk, rst_b, dcs, wr_n, rd_n, doe;
  logic [7:0] din, dout, mac;
  logic [2:0] fmt;
  logic [8:0] fl; // Booster, idle, partial, awake, normal, invert, on, tear en, tear mode
  int n_errors, checked;
  logic [19:0] vec [3] = '{{8'h88, 3'b011, 9'h155}, {8'h70, 3'b101, 9'h0aa}, {8'hf8, 3'b110, 9'h1ff}};
  status_readback status_readback_inst (.clk(clk), .rst_b(rst_b), .data_command_select(dcs),
    .write_strobe_n(wr_n), .read_strobe_n(rd_n), .data_in(din), .data_out(dout), .data_oe(doe),
    .memory_access_control(mac), .pixel_format_field(fmt), .idle_active_flag(fl[7]),
    .partial_active_flag(fl[6]), .awake_flag(fl[5]), .normal_display_flag(fl[4]),
    .inversion_active_flag(fl[3]), .display_on_flag(fl[2]), .tear_output_enable_flag(fl[1]),
    .tear_output_mode_flag(fl[0]), .booster_ok_flag(fl[8]));
  status_host_model status_host_model_inst (.clk(clk), .data_command_select(dcs), .write_strobe_n(wr_n),
    .read_strobe_n(rd_n), .data_in(din), .data_out(dout), .data_oe(doe));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Expected words built from the live mode inputs, dummy byte first
  function automatic logic [39:0] sw_exp();
    return {8'h00, fl[8], mac[7:3], 3'b000, fmt, fl[7:4], 2'b00, fl[3], 2'b00, fl[2:1], 3'b000, fl[0], 5'h00};
  endfunction
  function automatic logic [39:0] pm_exp();
    return {8'h00, fl[8:4], fl[2], 26'h0};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Command, optional aborting data write, then n reads compared in order
  task automatic seq(input logic [7:0] c, input logic [39:0] e, input int n, input bit ab);
    logic [7:0] b;
    status_host_model_inst.send(1'b0, c);
    if (ab) begin
      status_host_model_inst.send(1'b1, 8'h55);
    end
    for (int i = 0; i < n; i++) begin
      status_host_model_inst.fetch(b);
      chk(b, e[39-8*i -: 8]);
    end
  endtask
  task automatic wrap_up();
    $display("mismatches %0d comparisons %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Reset, defaults, every mode vector, then refusals and a second reset
  initial begin
    {rst_b, mac, fmt, fl, n_errors, checked} = {1'b0, 8'h00, 3'h6, 9'h010, 64'h0};
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    seq(8'h0a, 40'h0008000000, 2, 0);
    seq(8'h09, 40'h0000610000, 5, 0);
    foreach (vec[i]) begin
      {mac, fmt, fl} <= vec[i];
      @(posedge clk);
      seq(8'h09, sw_exp(), 5, 0);
      seq(8'h0a, pm_exp(), 3, 0);
    end
    seq(8'h0b, 40'h0, 2, 0);
    seq(8'h09, 40'h0, 2, 1);
    {mac, fmt, fl, rst_b} <= {8'h00, 3'h6, 9'h010, 1'b0};
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    seq(8'h0a, 40'h0008000000, 2, 0);
    wrap_up();
  end
endmodule // tb_status_readback
